// ===== core/lso_pkg.sv
// package for the load/store ordering block: types, region table, steps
// assumes one clock domain; shared by the core, the link interface and helpers
package lso_pkg;

  // transfer element size, which also picks the byte-order granularity
  typedef enum logic [1:0] {
    LSO_SZ_BYTE = 2'h0,
    LSO_SZ_HALF = 2'h1,
    LSO_SZ_WORD = 2'h2
  } lso_size_t;

  // main memory type, exactly one per region
  typedef enum logic [1:0] {
    LSO_MT_NORMAL = 2'h0,
    LSO_MT_DEVICE = 2'h1,
    LSO_MT_STRONG = 2'h2
  } lso_mtype_t;

  // cacheability class, meaningful for normal memory only
  typedef enum logic [1:0] {
    LSO_CA_NONE = 2'h0,
    LSO_CA_WT = 2'h1,
    LSO_CA_WB = 2'h2
  } lso_cache_t;

  // byte reverse operations
  typedef enum logic [1:0] {
    LSO_REV_WORD = 2'h0,
    LSO_REV_SHALF = 2'h1,
    LSO_REV_PACKED = 2'h2,
    LSO_REV_NONE = 2'h3
  } lso_revop_t;

  // region table, indexed by the top address bits, two bits per region for type and cache, one bit for share
  localparam int LSO_REGION_LSB = 29;
  localparam logic [15:0] LSO_REGION_TYPE = 16'h9410;
  localparam logic [7:0] LSO_REGION_SHARE = 8'hC4;
  localparam logic [15:0] LSO_REGION_CACHE = 16'h0086;

  // address steps and reset values
  localparam logic [31:0] LSO_HALF_STEP = 32'h00000002;
  localparam logic [31:0] LSO_WORD_STEP = 32'h00000004;
  localparam logic [31:0] LSO_RST_ADDR = 32'h00000000;
  localparam logic [31:0] LSO_RST_DATA = 32'h00000000;

endpackage

// ===== core/lso_link_if.sv
// interface joining the core to its byte reverser and region decoder
// assumes all three sit in the same clock domain; purely combinational
`timescale 1ns/100ps
`default_nettype none
interface lso_link_if;
  import lso_pkg::*;
  logic [31:0] rev_in;
  lso_revop_t rev_op;
  logic [31:0] rev_out;
  logic [31:0] attr_addr;
  lso_mtype_t attr_type;
  logic attr_share;
  lso_cache_t attr_cache;
  modport rev (input rev_in, input rev_op, output rev_out);
  modport attr (input attr_addr, output attr_type, output attr_share, output attr_cache);
endinterface
`default_nettype wire

// ===== core/lso_byte_rev.sv
// byte reversal datapath for word, signed halfword and packed halfwords
// assumes the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module lso_byte_rev (
  // link to the core
  lso_link_if.rev lnk
);
  import lso_pkg::*;

  logic [31:0] in_w;
  logic [31:0] word_rev;
  logic [31:0] shalf_rev;
  logic [31:0] packed_rev;

  // all four candidates are cheap, select afterwards
  assign in_w = lnk.rev_in;
  assign word_rev = {in_w[7:0], in_w[15:8], in_w[23:16], in_w[31:24]}; // [RL5]
  assign shalf_rev = {{16{in_w[7]}}, in_w[7:0], in_w[15:8]}; // [RL6]
  assign packed_rev = {in_w[23:16], in_w[31:24], in_w[7:0], in_w[15:8]}; // [RL7]
  assign lnk.rev_out = (lnk.rev_op == LSO_REV_WORD) ? word_rev :
                       (lnk.rev_op == LSO_REV_SHALF) ? shalf_rev :
                       (lnk.rev_op == LSO_REV_PACKED) ? packed_rev : in_w;
endmodule
`default_nettype wire

// ===== core/lso_attr_dec.sv
// region decoder: address to memory type, shareability and cacheability
// assumes the region table in the package; illegal codes degrade safely
`timescale 1ns/100ps
`default_nettype none
module lso_attr_dec (
  // link to the core
  lso_link_if.attr lnk
);
  import lso_pkg::*;

  logic [2:0] idx;
  logic [1:0] raw_type;
  logic [1:0] raw_cache;
  logic is_strong;
  logic is_normal;

  // table lookup on the top address bits
  assign idx = lnk.attr_addr[LSO_REGION_LSB +: 3];
  assign raw_type = LSO_REGION_TYPE[{idx, 1'b0} +: 2];
  assign raw_cache = LSO_REGION_CACHE[{idx, 1'b0} +: 2];
  // an unused type code falls to strongly-ordered, the safest ordering
  assign is_strong = (raw_type == 2'h2) || (raw_type == 2'h3);
  assign is_normal = (raw_type == 2'h0);
  assign lnk.attr_type = is_strong ? LSO_MT_STRONG : lso_mtype_t'(raw_type); // [RL9]
  assign lnk.attr_share = is_strong | LSO_REGION_SHARE[idx]; // [RL10] [RL11]
  // device and strongly-ordered memory are never cached
  assign lnk.attr_cache = (is_normal && raw_cache != 2'h3) ?
                          lso_cache_t'(raw_cache) : LSO_CA_NONE; // [RL13]
endmodule
`default_nettype wire

// ===== core/lso_core.sv
// load/store path: halfword fetch, element-sized endian steering,
// byte reverse unit and one-at-a-time memory port with region attributes
// assumes the memory side answers each request, held here until then, with one ack pulse
//
// Operation
// [RL1] fetches are always halfword aligned, bit 0 forced low
// [RL2] wide instruction built from lower then upper halfword, even byte low
// [RL3] endian mapping applied per transferred element, not whole transfer
// [RL4] byte, halfword and word elements per load/store class
// [RL5] word reverse swaps all four bytes
// [RL6] signed halfword reverse swaps low half bytes, sign extends
// [RL7] packed reverse swaps bytes within each halfword
// [RL8] no exclusive accesses and no exclusive monitor
// [RL9] each region has exactly one of normal, device, strongly-ordered
// [RL10] normal and device regions carry a shareability flag
// [RL11] strongly-ordered regions are always shareable
// [RL12] strongly-ordered accesses happen and are seen in program order
// [RL13] normal regions are non-cacheable, write-through or write-back
// [RL14] after several writes the value equals one whole write
// [RL15] a racing read sees whole old or whole new value
// [RL16] atomic only for bytes, aligned halfwords, aligned words
// [RL17] multiple transfers are a sequence of aligned word transactions
// [RL18] non-atomic accesses split into smaller atomic accesses; here misaligned ones fault instead, never split
// [RL19] fetches atomic per halfword; line fills leave atomicity alone
// [RL20] device and strongly-ordered atomic writes are multi-copy atomic
// [RL21] writes to one location serialized in one observed order
// [RL22] normal memory may still merge writes
// [RL23] fetched instructions are always little-endian
// [RL24] little-endian puts the lowest address in the least significant lane
// [RL25] type, shareability and cacheability travel with each request
`timescale 1ns/100ps
`default_nettype none
module lso_core #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // endianness strap and status
  input wire logic big_endian_strap,
  output logic big_endian,
  // instruction fetch
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  output logic if_ready,
  output logic if_valid,
  output logic if_wide,
  output logic [31:0] if_instr,
  // data load and store
  input wire logic ls_req,
  input wire logic ls_write,
  input wire lso_pkg::lso_size_t ls_size,
  input wire logic ls_signed,
  input wire logic ls_multi,
  input wire logic [CNT_W-1:0] ls_count,
  input wire logic [31:0] ls_addr,
  input wire logic [31:0] ls_wdata,
  output logic ls_ready,
  output logic ls_wnext,
  output logic ls_rvalid,
  output logic [31:0] ls_rdata,
  output logic ls_done,
  output logic ls_fault,
  // byte reverse unit
  input wire lso_pkg::lso_revop_t rev_op,
  input wire logic [31:0] rev_in,
  output logic [31:0] rev_out,
  // memory port
  output logic mem_req,
  output logic [31:0] mem_addr,
  output var lso_pkg::lso_size_t mem_size,
  output logic mem_write,
  output logic [3:0] mem_strb,
  output logic [31:0] mem_wdata,
  output var lso_pkg::lso_mtype_t mem_type,
  output logic mem_share,
  output var lso_pkg::lso_cache_t mem_cache,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import lso_pkg::*;

  typedef enum logic [3:0] {
    LSO_ST_IDLE = 4'h1,
    LSO_ST_FH1 = 4'h2,
    LSO_ST_FH2 = 4'h4,
    LSO_ST_DATA = 4'h8
  } lso_state_t;

  lso_state_t state_q, state_d;
  logic [31:0] addr_q, addr_d, hw_pair_q, wdata_q, rdata_q, rev_q;
  logic [15:0] hw1_q;
  lso_size_t size_q, st_size;
  logic write_q, signed_q, strap_seen_q, big_q;
  logic [CNT_W-1:0] beats_q;
  logic if_valid_q, if_wide_q, rvalid_q, done_q, fault_q;
  logic st_idle, st_fh1, st_fh2, st_data, take_ls, take_if, misalign, more_beats;
  logic [15:0] fetch_hw, rd_half_raw, rd_half, wr_half;
  logic fetch_wide;
  logic [31:0] rd_shift, rd_rev, rd_word, ld_value, wr_steer, wr_rev;
  logic [7:0] rd_byte;

  lso_link_if lnk();
  lso_byte_rev u_rev (.lnk(lnk.rev));
  lso_attr_dec u_attr (.lnk(lnk.attr));

  // state decode and request acceptance; data wins over fetch
  assign st_idle = (state_q == LSO_ST_IDLE);
  assign st_fh1 = (state_q == LSO_ST_FH1);
  assign st_fh2 = (state_q == LSO_ST_FH2);
  assign st_data = (state_q == LSO_ST_DATA);
  assign ls_ready = st_idle;
  assign if_ready = st_idle & ~ls_req;
  assign take_ls = ls_req & st_idle;
  assign take_if = if_req & if_ready;
  assign more_beats = (beats_q > CNT_W'(1));
  assign ls_wnext = st_data & mem_ack & write_q & more_beats;

  // only naturally aligned accesses are atomic, so others fault here
  assign misalign = (ls_multi || ls_size == LSO_SZ_WORD) ? (ls_addr[1:0] != 2'h0) :
                    (ls_size == LSO_SZ_HALF) ? ls_addr[0] : 1'b0; // [RL16] [RL18]

  // fetch lane: never byte swapped, even byte lands in bits 7:0
  assign fetch_hw = addr_q[1] ? mem_rdata[31:16] : mem_rdata[15:0]; // [RL2] [RL23]
  assign fetch_wide = (fetch_hw[15:13] == 3'h7) && (fetch_hw[12:11] != 2'h0);

  // load steering, swap only inside the element itself
  assign rd_shift = mem_rdata >> {addr_q[1:0], 3'b000};
  assign rd_byte = rd_shift[7:0]; // [RL24]
  assign rd_half_raw = addr_q[1] ? mem_rdata[31:16] : mem_rdata[15:0];
  assign rd_half = big_q ? {rd_half_raw[7:0], rd_half_raw[15:8]} : rd_half_raw; // [RL3]
  assign rd_rev = {mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16], mem_rdata[31:24]};
  assign rd_word = big_q ? rd_rev : mem_rdata; // [RL3]
  assign ld_value = (size_q == LSO_SZ_BYTE) ?
                      (signed_q ? {{24{rd_byte[7]}}, rd_byte} : {24'h000000, rd_byte}) :
                    (size_q == LSO_SZ_HALF) ?
                      (signed_q ? {{16{rd_half[15]}}, rd_half} : {16'h0000, rd_half}) :
                    rd_word; // [RL4]

  // store steering: element replicated on every lane, strobes pick it
  assign st_size = st_idle ? (ls_multi ? LSO_SZ_WORD : ls_size) : size_q;
  assign wr_half = big_q ? {ls_wdata[7:0], ls_wdata[15:8]} : ls_wdata[15:0];
  assign wr_rev = {ls_wdata[7:0], ls_wdata[15:8], ls_wdata[23:16], ls_wdata[31:24]};
  assign wr_steer = (st_size == LSO_SZ_BYTE) ? {4{ls_wdata[7:0]}} :
                    (st_size == LSO_SZ_HALF) ? {2{wr_half}} :
                    (big_q ? wr_rev : ls_wdata); // [RL3] [RL4]

  // next address: aligned fetch, +2 for the second halfword, +4 per beat
  assign addr_d = take_ls ? ls_addr :
                  take_if ? {if_addr[31:1], 1'b0} : // [RL1]
                  (st_fh1 & mem_ack) ? addr_q + LSO_HALF_STEP : // [RL2]
                  (st_data & mem_ack & more_beats) ? addr_q + LSO_WORD_STEP : // [RL17]
                  addr_q;

  // sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      LSO_ST_IDLE:
      begin
        if (take_ls && !misalign)
          state_d = LSO_ST_DATA;
        else if (take_if)
          state_d = LSO_ST_FH1;
      end
      LSO_ST_FH1:
      begin
        if (mem_ack)
          state_d = fetch_wide ? LSO_ST_FH2 : LSO_ST_IDLE;
      end
      LSO_ST_FH2:
      begin
        if (mem_ack)
          state_d = LSO_ST_IDLE;
      end
      LSO_ST_DATA:
      begin
        if (mem_ack && !more_beats)
          state_d = LSO_ST_IDLE;
      end
      default: state_d = LSO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= LSO_ST_IDLE;
      addr_q <= LSO_RST_ADDR;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // request shape is latched once, so a multi-beat stays word sized
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      size_q <= LSO_SZ_HALF;
      write_q <= 1'b0;
      signed_q <= 1'b0;
      beats_q <= '0;
    end
    else if (take_ls)
    begin
      size_q <= st_size; // [RL17]
      write_q <= ls_write;
      signed_q <= ls_signed;
      beats_q <= (ls_multi && ls_count != '0) ? ls_count : CNT_W'(1);
    end
    else if (take_if)
    begin
      size_q <= LSO_SZ_HALF; // [RL19]
      write_q <= 1'b0;
    end
    else if (st_data && mem_ack)
      beats_q <= beats_q - CNT_W'(1);
  end

  // write data register, refreshed per beat from the next word
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wdata_q <= LSO_RST_DATA;
    else if (take_ls || ls_wnext)
      wdata_q <= wr_steer;
  end

  // fetch assembly: first halfword on the left, as decoded
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hw1_q <= 16'h0000;
      hw_pair_q <= LSO_RST_DATA;
      if_valid_q <= 1'b0;
      if_wide_q <= 1'b0;
    end
    else
    begin
      if_valid_q <= (st_fh1 & mem_ack & ~fetch_wide) | (st_fh2 & mem_ack);
      if (st_fh1 && mem_ack)
      begin
        hw1_q <= fetch_hw;
        hw_pair_q <= {fetch_hw, 16'h0000};
        if_wide_q <= fetch_wide;
      end
      else if (st_fh2 && mem_ack)
        hw_pair_q <= {hw1_q, fetch_hw}; // [RL2]
    end
  end

  // load results and completion pulses
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_q <= LSO_RST_DATA;
      rvalid_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= st_data & mem_ack & ~write_q;
      done_q <= st_data & mem_ack & ~more_beats;
      fault_q <= take_ls & misalign;
      if (st_data && mem_ack && !write_q)
        rdata_q <= ld_value;
    end
  end

  // strap caught on the first edge after release, not by the reset itself
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_seen_q <= 1'b0;
      big_q <= 1'b0;
      rev_q <= LSO_RST_DATA;
    end
    else
    begin
      rev_q <= lnk.rev_out; // [RL5] [RL6] [RL7]
      if (!strap_seen_q)
      begin
        strap_seen_q <= 1'b1;
        big_q <= big_endian_strap;
      end
    end
  end

  // helper links
  assign lnk.rev_in = rev_in;
  assign lnk.rev_op = rev_op;
  assign lnk.attr_addr = addr_q;

  // one request in flight, held to ack, whole element per transaction;
  // no exclusive flavour exists, a plain request is all the port offers
  assign mem_req = ~st_idle; // [RL8] [RL12] [RL14] [RL15] [RL20] [RL21]
  assign mem_addr = addr_q;
  assign mem_size = size_q;
  assign mem_write = write_q & st_data;
  assign mem_wdata = wdata_q;
  assign mem_strb = (size_q == LSO_SZ_BYTE) ? (4'h1 << addr_q[1:0]) :
                    (size_q == LSO_SZ_HALF) ? (addr_q[1] ? 4'hC : 4'h3) : 4'hF;
  // attributes ride with the request; normal merging is left to memory
  assign mem_type = lnk.attr_type; // [RL25] [RL22]
  assign mem_share = lnk.attr_share; // [RL25]
  assign mem_cache = lnk.attr_cache; // [RL25]

  assign big_endian = big_q;
  assign if_valid = if_valid_q;
  assign if_wide = if_wide_q;
  assign if_instr = hw_pair_q;
  assign ls_rvalid = rvalid_q;
  assign ls_rdata = rdata_q;
  assign ls_done = done_q;
  assign ls_fault = fault_q;
  assign rev_out = rev_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] rin_word, rin_pack;
  assign rin_word = {rev_in[7:0], rev_in[15:8], rev_in[23:16], rev_in[31:24]};
  assign rin_pack = {rev_in[23:16], rev_in[31:24], rev_in[7:0], rev_in[15:8]};

  fetch_align_a: assert property ( // [RL1]
    (st_fh1 || st_fh2) |-> !mem_addr[0] && mem_size == LSO_SZ_HALF)
    else $error("fetch not halfword aligned");
  hw_order_a: assert property ( // [RL2]
    (st_fh1 && mem_ack && fetch_wide) |=> st_fh2 && mem_addr == $past(mem_addr) + 32'h2)
    else $error("second halfword not at next address");
  instr_pair_a: assert property ( // [RL23]
    (st_fh2 && mem_ack) |=> if_valid && if_instr == {$past(hw1_q), $past(fetch_hw)})
    else $error("wide instruction assembled wrong");
  word_order_a: assert property ( // [RL3]
    (st_data && mem_ack && !write_q && size_q == LSO_SZ_WORD)
      |=> ls_rdata == ($past(big_q) ? $past({mem_rdata[7:0], mem_rdata[15:8],
      mem_rdata[23:16], mem_rdata[31:24]}) : $past(mem_rdata)))
    else $error("word load byte order wrong");
  byte_lane_a: assert property ( // [RL24]
    (st_data && mem_ack && !write_q && size_q == LSO_SZ_BYTE && !signed_q
      && addr_q[1:0] == 2'h0) |=> ls_rdata == {24'h000000, $past(mem_rdata[7:0])})
    else $error("byte load lane wrong");
  rev_word_a: assert property ( // [RL5]
    rev_op == LSO_REV_WORD |=> rev_out == $past(rin_word))
    else $error("word reverse wrong");
  rev_shalf_a: assert property ( // [RL6]
    rev_op == LSO_REV_SHALF |=> rev_out[31:16] == {16{rev_out[15]}}
      && rev_out[15:0] == $past(rin_word[31:16]))
    else $error("signed half reverse wrong");
  rev_packed_a: assert property ( // [RL7]
    rev_op == LSO_REV_PACKED |=> rev_out == $past(rin_pack))
    else $error("packed reverse wrong");
  strong_share_a: assert property ( // [RL11]
    mem_req && mem_type == LSO_MT_STRONG |-> mem_share)
    else $error("strongly-ordered not shareable");
  cache_class_a: assert property ( // [RL13]
    mem_req && mem_type != LSO_MT_NORMAL |-> mem_cache == LSO_CA_NONE)
    else $error("non-normal region cached");
  req_hold_a: assert property ( // [RL12]
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("request changed before ack");
  multi_step_a: assert property ( // [RL17]
    st_data && mem_ack && more_beats |=> mem_req && mem_size == LSO_SZ_WORD
      && mem_addr == $past(mem_addr) + 32'h4)
    else $error("multiple beat step wrong");
  data_align_a: assert property ( // [RL16]
    st_data |-> (mem_size == LSO_SZ_WORD) ? mem_addr[1:0] == 2'h0 :
      (mem_size == LSO_SZ_HALF) ? !mem_addr[0] : 1'b1)
    else $error("unaligned data transaction");

  wide_fetch_c: cover property (st_fh2 && mem_ack);
  multi_load_c: cover property (st_data && mem_ack && !write_q && more_beats);
  big_half_c: cover property (st_data && mem_ack && big_q && size_q == LSO_SZ_HALF);
  fault_c: cover property (take_ls && misalign);
endmodule
`default_nettype wire

// ===== verification/lso_mem_model.sv
// memory-side partner: word memory with lane strobes and a programmable wait
// assumes one request at a time, held by the core until the ack pulse
`timescale 1ns/100ps
`default_nettype none
module lso_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request from the core
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_strb,
  input wire logic [31:0] mem_wdata,
  // answer timing
  input wire logic [3:0] wait_cycles,
  // answer
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q;
  logic [3:0] cnt_q;
  wire [7:0] idx = mem_addr[9:2];

  // one transaction per ack, completed whole in one edge so no torn value
  // requests served strictly in arrival order, one location at a time
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_ack <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 32'h00000000;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (mem_req && cnt_q >= wait_cycles)
    begin
      mem_ack <= 1'b1;
      last_q <= mem[idx]; // read sees the old value
      for (int k = 0; k < 4; k++)
        if (mem_write && mem_strb[k])
          mem[idx][8*k +: 8] <= mem_wdata[8*k +: 8];
    end
    else if (mem_req)
      cnt_q <= cnt_q + 4'h1;
  end

  // data only valid with ack; otherwise the inverse so a stale read shows
  assign mem_rdata = mem_ack ? last_q : ~last_q;
endmodule
`default_nettype wire

// ===== verification/lso_core_tb.sv
// self-checking bench for the load/store ordering block
// assumes the partner model on the memory port; the bench drives the endian strap
`timescale 1ns/100ps
`default_nettype none
module lso_core_tb;
  import lso_pkg::*;
  typedef struct {
    lso_revop_t rop;
    logic [31:0] rexp;
    lso_size_t sz;
    logic sgn;
    logic [31:0] addr;
    logic [31:0] dexp;
    lso_mtype_t mt;
    logic sh;
    lso_cache_t ca;
  } lso_tb_row_t;
  logic clk = 1'b0;
  logic strap = 1'b0;
  logic sys_rst, if_req, ls_req, ls_write, ls_signed, ls_multi;
  logic [31:0] if_addr, ls_addr, ls_wdata, rev_in, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] if_instr, ls_rdata, rev_out;
  logic [3:0] ls_count, mem_strb, wait_cycles;
  lso_size_t ls_size, mem_size;
  lso_revop_t rev_op;
  lso_mtype_t mem_type;
  lso_cache_t mem_cache;
  logic big_endian, if_ready, if_valid, if_wide, ls_ready, ls_wnext, ls_rvalid;
  logic ls_done, ls_fault, mem_req, mem_write, mem_share, mem_ack;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] q_rd[$];
  logic got_fault, got_done, seen_req, at_share;
  lso_mtype_t at_type;
  lso_cache_t at_cache;
  lso_tb_row_t rows[7];

  always #25 clk = ~clk;

  lso_core u_dut (.clk(clk), .sys_rst(sys_rst), .big_endian_strap(strap),
    .big_endian(big_endian), .if_req(if_req), .if_addr(if_addr), .if_ready(if_ready),
    .if_valid(if_valid), .if_wide(if_wide), .if_instr(if_instr), .ls_req(ls_req),
    .ls_write(ls_write), .ls_size(ls_size), .ls_signed(ls_signed), .ls_multi(ls_multi),
    .ls_count(ls_count), .ls_addr(ls_addr), .ls_wdata(ls_wdata), .ls_ready(ls_ready),
    .ls_wnext(ls_wnext), .ls_rvalid(ls_rvalid), .ls_rdata(ls_rdata), .ls_done(ls_done),
    .ls_fault(ls_fault), .rev_op(rev_op), .rev_in(rev_in), .rev_out(rev_out),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size), .mem_write(mem_write),
    .mem_strb(mem_strb), .mem_wdata(mem_wdata), .mem_type(mem_type),
    .mem_share(mem_share), .mem_cache(mem_cache), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  lso_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_strb(mem_strb),
    .mem_wdata(mem_wdata), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // fetch: request held for the taking edge only, then wait for the pulse
  task automatic fetch(input logic [31:0] a, output logic wide, output logic [31:0] ins);
    if_req = 1'b1;
    if_addr = a;
    @(posedge clk);
    #1 if_req = 1'b0;
    for (int n = 0; n < 30 && !if_valid; n++)
      @(posedge clk) #1;
    wide = if_wide;
    ins = if_instr;
  endtask

  // data access: collects read beats, fault, done and first-beat attributes
  task automatic do_ls(input logic w, input lso_size_t sz, input logic sg, input logic mu,
                       input logic [3:0] cnt, input logic [31:0] a, input logic [31:0] wd);
    q_rd.delete();
    got_fault = 1'b0;
    got_done = 1'b0;
    seen_req = 1'b0;
    ls_req = 1'b1;
    ls_write = w;
    ls_size = sz;
    ls_signed = sg;
    ls_multi = mu;
    ls_count = cnt;
    ls_addr = a;
    ls_wdata = wd;
    @(posedge clk);
    #1 ls_req = 1'b0;
    for (int n = 0; n < 60 && !got_fault && !got_done; n++)
    begin
      if (mem_req && !seen_req)
      begin
        seen_req = 1'b1;
        at_type = mem_type;
        at_share = mem_share;
        at_cache = mem_cache;
      end
      // sample before waiting: the fault pulse stands only in the cycle after taking
      if (ls_wnext)
        ls_wdata = ~ls_wdata;
      if (ls_rvalid)
        q_rd.push_back(ls_rdata);
      got_fault = ls_fault;
      got_done = ls_done;
      @(posedge clk) #1;
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test;
    end
  end

  initial
  begin
    logic wide;
    logic [31:0] ins;
    rows = '{
      '{LSO_REV_WORD, 32'hA5F01280, LSO_SZ_BYTE, 1'b0, 32'h20000101, 32'h000000D3,
        LSO_MT_NORMAL, 1'b0, LSO_CA_WT},
      '{LSO_REV_SHALF, 32'hFFFFA5F0, LSO_SZ_BYTE, 1'b1, 32'h40000103, 32'hFFFFFFF1,
        LSO_MT_DEVICE, 1'b1, LSO_CA_NONE},
      '{LSO_REV_PACKED, 32'h1280A5F0, LSO_SZ_HALF, 1'b1, 32'hE0000102, 32'hFFFFF1E2,
        LSO_MT_STRONG, 1'b1, LSO_CA_NONE},
      '{LSO_REV_NONE, 32'h8012F0A5, LSO_SZ_HALF, 1'b0, 32'h00000100, 32'h0000D3C4,
        LSO_MT_NORMAL, 1'b0, LSO_CA_WB},
      '{LSO_REV_WORD, 32'hA5F01280, LSO_SZ_WORD, 1'b0, 32'hC0000100, 32'hF1E2D3C4,
        LSO_MT_DEVICE, 1'b1, LSO_CA_NONE},
      '{LSO_REV_SHALF, 32'hFFFFA5F0, LSO_SZ_BYTE, 1'b0, 32'hA0000100, 32'h000000C4,
        LSO_MT_DEVICE, 1'b0, LSO_CA_NONE},
      '{LSO_REV_PACKED, 32'h1280A5F0, LSO_SZ_WORD, 1'b0, 32'h60000100, 32'hF1E2D3C4,
        LSO_MT_NORMAL, 1'b0, LSO_CA_WB}};
    sys_rst = 1'b1;
    {if_req, ls_req, ls_write, ls_signed, ls_multi} = 5'h00;
    if_addr = 32'h0;
    ls_addr = 32'h0;
    ls_wdata = 32'h0;
    ls_size = LSO_SZ_BYTE;
    ls_count = 4'h0;
    rev_op = LSO_REV_NONE;
    rev_in = 32'h8012F0A5;
    wait_cycles = 4'h0;
    u_mem.mem[8'h40] = 32'hF1E2D3C4;
    u_mem.mem[8'h80] = 32'hE8001234;
    u_mem.mem[8'h81] = 32'h00005A6B;
    repeat (2) @(posedge clk);
    #1 chk({30'h0, if_ready, ls_ready}, 32'h3, "idle in reset");
    chk({31'h0, mem_req}, 32'h0, "no request in reset");
    sys_rst = 1'b0;
    @(posedge clk) #1;
    // ordinary cases: reverse unit and loads across every region class
    foreach (rows[i])
    begin
      rev_op = rows[i].rop;
      @(posedge clk) #1 chk(rev_out, rows[i].rexp, "byte reverse");
      do_ls(1'b0, rows[i].sz, rows[i].sgn, 1'b0, 4'h0, rows[i].addr, 32'h0);
      chk((q_rd.size() == 1) ? q_rd[0] : 32'hDEADDEAD, rows[i].dexp, "load");
      chk({30'h0, at_type}, {30'h0, rows[i].mt}, "region type");
      chk({31'h0, at_share}, {31'h0, rows[i].sh}, "shareable");
      chk({30'h0, at_cache}, {30'h0, rows[i].ca}, "cacheability");
    end
    // narrow fetch from an odd address lands on the even halfword
    fetch(32'h00000201, wide, ins);
    chk({wide, ins[31:1]}, {1'b0, 31'h091A0000}, "narrow fetch");
    // wide fetch straddling two words, lower halfword first
    fetch(32'h00000202, wide, ins);
    chk(ins, 32'hE8005A6B, "wide fetch");
    chk({31'h0, wide}, 32'h1, "wide flag");
    // byte then halfword store, read back whole word
    do_ls(1'b1, LSO_SZ_BYTE, 1'b0, 1'b0, 4'h0, 32'h20000101, 32'h00000077);
    do_ls(1'b1, LSO_SZ_HALF, 1'b0, 1'b0, 4'h0, 32'hE0000102, 32'h0000BEEF);
    do_ls(1'b0, LSO_SZ_WORD, 1'b0, 1'b0, 4'h0, 32'h00000100, 32'h0);
    chk(q_rd[0], 32'hBEEF77C4, "store lanes");
    // slow memory, two-beat load multiple
    wait_cycles = 4'h3;
    do_ls(1'b0, LSO_SZ_WORD, 1'b0, 1'b1, 4'h2, 32'h00000200, 32'h0);
    chk(32'(q_rd.size()), 32'd2, "beat count");
    chk(q_rd[0], 32'hE8001234, "beat 0");
    chk(q_rd[1], 32'h00005A6B, "beat 1");
    // store multiple: second word is the inverse, handed over on the first ack
    do_ls(1'b1, LSO_SZ_WORD, 1'b0, 1'b1, 4'h2, 32'h00000300, 32'h0F1E2D3C);
    do_ls(1'b0, LSO_SZ_WORD, 1'b0, 1'b1, 4'h2, 32'h00000300, 32'h0);
    chk(q_rd[0], 32'h0F1E2D3C, "store beat 0");
    chk(q_rd[1], 32'hF0E1D2C3, "store beat 1");
    wait_cycles = 4'h0;
    // misaligned word and halfword are refused without a memory access
    do_ls(1'b0, LSO_SZ_WORD, 1'b0, 1'b0, 4'h0, 32'h20000102, 32'h0);
    chk({30'h0, got_fault, seen_req}, 32'h2, "misaligned word");
    do_ls(1'b1, LSO_SZ_HALF, 1'b0, 1'b0, 4'h0, 32'h20000101, 32'h0);
    chk({30'h0, got_fault, seen_req}, 32'h2, "misaligned half");
    // reset cutting a slow load in flight, then a big-endian strap
    wait_cycles = 4'h3;
    ls_write = 1'b0;
    ls_addr = 32'h00000100;
    ls_req = 1'b1;
    @(posedge clk) #1 ls_req = 1'b0;
    chk({31'h0, mem_req}, 32'h1, "load in flight");
    sys_rst = 1'b1;
    strap = 1'b1;
    @(posedge clk) #1 chk({30'h0, mem_req, big_endian}, 32'h0, "cut by reset");
    sys_rst = 1'b0;
    wait_cycles = 4'h0;
    @(posedge clk) #1 chk({31'h0, big_endian}, 32'h1, "strap caught");
    do_ls(1'b0, LSO_SZ_WORD, 1'b0, 1'b0, 4'h0, 32'h00000100, 32'h0);
    chk(q_rd[0], 32'hC477EFBE, "big word");
    do_ls(1'b0, LSO_SZ_HALF, 1'b0, 1'b0, 4'h0, 32'h00000102, 32'h0);
    chk(q_rd[0], 32'h0000EFBE, "big half");
    do_ls(1'b0, LSO_SZ_BYTE, 1'b0, 1'b0, 4'h0, 32'h00000101, 32'h0);
    chk(q_rd[0], 32'h00000077, "big byte");
    stop_test;
  end
endmodule
`default_nettype wire
